// ---- verilog/ads_pkg.sv ----
package ads_pkg;
   // ==========================================
   // sizes and timing
   localparam int CHANNEL_COUNT    = 11;
   localparam int RESULT_BITS      = 12;
   localparam int WORD_BITS        = 16;
   localparam int CHAN_BITS        = 4;
   localparam int LEN_BITS         = 7;
   localparam int SYS_CLK_HZ       = 100_000_000;
   localparam int CONV_CLK_HZ      = 10_000_000;
   localparam int CONV_TICK_CYCLES = SYS_CLK_HZ / CONV_CLK_HZ;
   // ==========================================
   // sample length fields
   localparam int LOW_GROUP_LAST   = 4;
   localparam int MID_GROUP_LAST   = 7;
   localparam int MID_FIELD_LSB    = 4;
   localparam int MID_MODE_BIT     = 7;
   localparam int MID_STEP         = 8;
   localparam int MID_OFFSET       = 7;
   localparam int HIGH_MODE_BIT    = 1;
   localparam int HIGH_STEP        = 16;
   localparam int HIGH_OFFSET      = 12;
   localparam logic [6:0] SAMPLE_FLOOR = 7'h01;
   // ==========================================
   // result layout
   localparam int RIGHT_LSB        = 0;
   localparam int LEFT_LSB         = 3;
   localparam logic [15:0] RESULT_RESET = 16'h0000;
   // ==========================================
   // triggered jobs
   localparam int JOB_COUNT   = 9;
   localparam int JOB_FOC_A   = 0;
   localparam int JOB_FOC_B   = 1;
   localparam int JOB_FOC_BUS = 2;
   localparam int JOB_FOC_C   = 3;
   localparam int JOB_TIM_BUS = 4;
   localparam int JOB_TIM_U   = 5;
   localparam int JOB_TIM_V   = 6;
   localparam int JOB_TIM_W   = 7;
   localparam int JOB_LIN     = 8;
   localparam logic [3:0] JOB_CHANNEL [JOB_COUNT] =
      '{4'h0, 4'h1, 4'h2, 4'h4, 4'h4, 4'ha, 4'h9, 4'h8, 4'h0};

   typedef enum logic [2:0] {ST_IDLE = 3'b001, ST_SAMPLE = 3'b010, ST_CONVERT = 3'b100} ads_state_type;
   typedef enum logic [1:0] {DEST_FOC = 2'h1, DEST_TIMER = 2'h2, DEST_LIN = 2'h3} ads_dest_type;
   typedef enum logic [1:0] {SHUNT_SINGLE = 2'h0, SHUNT_DUAL = 2'h1, SHUNT_TRIPLE = 2'h2} ads_shunt_type;

   localparam ads_dest_type JOB_DEST [JOB_COUNT] = '{DEST_FOC, DEST_FOC, DEST_FOC, DEST_FOC,
      DEST_TIMER, DEST_TIMER, DEST_TIMER, DEST_TIMER, DEST_LIN};

   typedef struct packed {
      logic focCurrent;
      logic focVoltage;
      logic timerCurrent;
      logic timerPosition;
      logic lin;
   } ads_trig_type;

   typedef struct packed {
      logic          focEnable;
      ads_shunt_type shuntMode;
      logic          busVoltageChannelSelect;
      logic          timerOneEnable;
      logic          positionSourceSelect;
   } ads_mode_type;

   typedef struct packed {
      ads_dest_type   dest;
      logic [3:0]     channel;
      logic [15:0]    data;
   } ads_result_type;

   function automatic logic [15:0] align(input logic [11:0] d, input logic left);
      align = left ? {1'b0, d, 3'h0} : {4'h0, d};
   endfunction : align

   function automatic logic [3:0] lowest_set(input logic [15:0] v);
      lowest_set = 4'h0;
      for (int i = 15; i >= 0; i--)
         if (v[i])
            lowest_set = 4'(i);
   endfunction : lowest_set
endpackage : ads_pkg

// ---- verilog/ads_sample_timer.sv ----
`timescale 1ns/1ns
module ads_sample_timer
   import ads_pkg::*;
#(
   parameter int TICK_CYCLES = ads_pkg::CONV_TICK_CYCLES
)
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_b,
   // control
   input  wire logic       start,
   input  wire logic [6:0] length,
   // status
   output logic            running,
   output logic            done
);
   import ads_pkg::*;
   // ==========================================
   // converter clock divider and sample counter
   logic [7:0] div;
   logic [6:0] count;
   logic [6:0] target;
   wire        tick = running && (div == 8'(TICK_CYCLES - 1));
   wire        last = tick && (count + 7'h01 >= target);

   assign done = last;

   always_ff @(posedge clk or negedge rst_b)
      if (!rst_b)
      begin
         div     <= 8'h00;
         count   <= 7'h00;
         target  <= 7'h00;
         running <= 1'b0;
      end
      else if (start)
      begin
         div     <= 8'h00;
         count   <= 7'h00;
         // a zero setting is raised to SAMPLE_FLOOR, one converter tick; software keeps it at 3 or more anyway
         target  <= (length == 7'h00) ? ads_pkg::SAMPLE_FLOOR : length;
         running <= 1'b1;
      end
      else if (running)
      begin
         div     <= tick ? 8'h00 : div + 8'h01;
         count   <= tick ? count + 7'h01 : count;
         running <= !last;
      end

   // ==========================================
   // checks
   a_tick_period: assert property (@(posedge clk) disable iff (!rst_b)
      tick && !done |=> !tick [*8]) else $error("converter tick faster than 10 MHz");
   a_sample_length: assert property (@(posedge clk) disable iff (!rst_b)
      done |-> count + 7'h01 == target) else $error("sample phase length wrong");
endmodule : ads_sample_timer

// ---- verilog/ads_result_mem.sv ----
`timescale 1ns/1ns
module ads_result_mem
#(
   parameter int DEPTH = 11,
   parameter int WIDTH = 16
)
(
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst_b,
   // write port
   input  wire logic             writeEnable,
   input  wire logic [3:0]       writeAddr,
   input  wire logic [WIDTH-1:0] writeData,
   // read port
   input  wire logic [3:0]       readAddr,
   output logic [WIDTH-1:0]      readData
);
   // ==========================================
   // one result word per channel
   logic [WIDTH-1:0] store [DEPTH];

   genvar e;
   generate
      for (e = 0; e < DEPTH; e++)
      begin : g_entry
         always_ff @(posedge clk or negedge rst_b)
            if (!rst_b)
               store[e] <= '0;
            else if (writeEnable && writeAddr == 4'(e))
               store[e] <= writeData;
      end
   endgenerate

   // unmapped channel numbers read as zero
   always_ff @(posedge clk or negedge rst_b)
      if (!rst_b)
         readData <= '0;
      else
         readData <= (32'(readAddr) < DEPTH) ? store[readAddr] : '0;
endmodule : ads_result_mem

// ---- verilog/ads_sequencer.sv ----
`timescale 1ns/1ns
module ads_sequencer
   import ads_pkg::*;
#(
   parameter logic [3:0] LIN_CHANNEL = 4'h3
)
(
   // clock and reset
   input  wire logic                  clk,
   input  wire logic                  rst_b,
   // software control
   input  wire logic                  converterEnable,
   input  wire logic                  startWrite,
   input  wire logic [10:0]           channelMask,
   input  wire logic                  resultAlignmentSelect,
   input  wire logic                  completionIrqEnable,
   input  wire logic                  completionClear,
   input  wire logic [7:0]            sampleLengthLowGroups,
   input  wire logic [1:0]            sampleLengthHighGroup,
   // software status
   output logic                       startBusyFlag,
   output logic                       completionFlag,
   output logic                       completionIrq,
   input  wire logic [3:0]            readChannel,
   output logic [15:0]                channelResult,
   // hardware triggers
   input  wire ads_pkg::ads_trig_type trigger,
   input  wire ads_pkg::ads_mode_type modeConfig,
   // triggered results
   output logic                       resultValid,
   output ads_pkg::ads_result_type    result,
   // converter macro
   output logic                       sampleHold,
   output logic [3:0]                 convChannel,
   output logic                       convertStart,
   input  wire logic                  convertDone,
   input  wire logic [11:0]           convertData
);
   import ads_pkg::*;

   // ==========================================
   // state
   ads_state_type              state;
   ads_state_type              next_state;
   logic [JOB_COUNT-1:0]       trigPending;
   logic [JOB_COUNT-1:0]       trigSet;
   logic [CHANNEL_COUNT-1:0]   seqPending;
   logic                       curTrig;
   logic [3:0]                 curJob;
   logic [3:0]                 jobChannel [JOB_COUNT];
   logic                       timerDone;

   // ==========================================
   // trigger decode
   wire focOn  = converterEnable && modeConfig.focEnable;
   wire timOn  = converterEnable && modeConfig.timerOneEnable;
   wire focCur = focOn && trigger.focCurrent;
   wire timPos = timOn && trigger.timerPosition && modeConfig.positionSourceSelect;

   assign trigSet[JOB_FOC_A]   = focCur && modeConfig.shuntMode != SHUNT_SINGLE;
   assign trigSet[JOB_FOC_B]   = focCur && modeConfig.shuntMode != SHUNT_SINGLE;
   assign trigSet[JOB_FOC_C]   = focCur && modeConfig.shuntMode != SHUNT_DUAL;
   assign trigSet[JOB_FOC_BUS] = focOn && trigger.focVoltage && modeConfig.busVoltageChannelSelect;
   assign trigSet[JOB_TIM_BUS] = timOn && trigger.timerCurrent;
   assign trigSet[JOB_TIM_U]   = timPos;
   assign trigSet[JOB_TIM_V]   = timPos;
   assign trigSet[JOB_TIM_W]   = timPos;
   assign trigSet[JOB_LIN]     = converterEnable && trigger.lin;

   // ==========================================
   // selection
   wire       trigAny    = |trigPending;
   wire       seqAny     = |seqPending;
   wire       idlePick   = state == ST_IDLE && converterEnable && (trigAny || seqAny);
   wire       takeJob    = idlePick && trigAny;
   wire       takeSeq    = idlePick && !trigAny;
   wire [3:0] pickJob    = lowest_set(16'(trigPending));
   wire [3:0] pickSeq    = lowest_set(16'(seqPending));
   wire [3:0] pickChan   = trigAny ? jobChannel[pickJob] : pickSeq;
   wire       convEnd    = state == ST_CONVERT && convertDone;
   wire       memWrite   = convEnd && !curTrig;
   wire       runEnd     = memWrite && !seqAny && startBusyFlag;
   wire       startTake  = startWrite && converterEnable && |channelMask && !startBusyFlag;

   // ==========================================
   // sample length per channel group
   wire [2:0] midField = sampleLengthLowGroups[MID_FIELD_LSB +: 3];
   wire [6:0] lowLen   = {3'h0, sampleLengthLowGroups[3:0]};
   wire [6:0] midLen   = sampleLengthLowGroups[MID_MODE_BIT] ?
                         7'(32'(midField) * MID_STEP + MID_OFFSET) : {4'h0, midField};
   wire [6:0] highLen  = 7'(32'(sampleLengthHighGroup) * HIGH_STEP
                         + (sampleLengthHighGroup[HIGH_MODE_BIT] ? 0 : HIGH_OFFSET));
   wire [6:0] pickLen  = (32'(pickChan) <= LOW_GROUP_LAST) ? lowLen :
                         (32'(pickChan) <= MID_GROUP_LAST) ? midLen : highLen;

   // ==========================================
   // pending triggered jobs
   genvar j;
   generate
      for (j = 0; j < JOB_COUNT; j++)
      begin : g_job
         assign jobChannel[j] = (j == JOB_LIN) ? LIN_CHANNEL : JOB_CHANNEL[j];
         // a new event in the cycle its job is taken stays pending
         always_ff @(posedge clk or negedge rst_b)
            if (!rst_b)
               trigPending[j] <= 1'b0;
            else if (trigSet[j])
               trigPending[j] <= 1'b1;
            else if (takeJob && pickJob == 4'(j))
               trigPending[j] <= 1'b0;
      end
   endgenerate

   // ==========================================
   // sequential run
   // bits drop only when picked or when the converter is disabled, so triggers may cut in between channels
   always_ff @(posedge clk or negedge rst_b)
      if (!rst_b)
         seqPending <= '0;
      else if (!converterEnable)
         seqPending <= '0;
      else if (startTake)
         seqPending <= channelMask;
      else if (takeSeq)
         seqPending[pickSeq] <= 1'b0;

   // disabling the converter abandons a run without raising completion
   always_ff @(posedge clk or negedge rst_b)
      if (!rst_b)
         startBusyFlag <= 1'b0;
      else if (startTake)
         startBusyFlag <= 1'b1;
      else if (runEnd || !converterEnable)
         startBusyFlag <= 1'b0;

   always_ff @(posedge clk or negedge rst_b)
      if (!rst_b)
         completionFlag <= 1'b0;
      else if (runEnd)
         completionFlag <= 1'b1;
      else if (completionClear)
         completionFlag <= 1'b0;

   assign completionIrq = completionFlag && completionIrqEnable;

   // ==========================================
   // conversion control
   always_comb
   begin
      next_state = state;
      unique case (state)
         ST_IDLE:    if (idlePick) next_state = ST_SAMPLE;
         ST_SAMPLE:  if (timerDone) next_state = ST_CONVERT;
         ST_CONVERT: if (convertDone) next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b)
      if (!rst_b)
      begin
         state       <= ST_IDLE;
         curTrig     <= 1'b0;
         curJob      <= 4'h0;
         convChannel <= 4'h0;
      end
      else
      begin
         state <= next_state;
         if (idlePick)
         begin
            curTrig     <= trigAny;
            curJob      <= pickJob;
            convChannel <= pickChan;
         end
      end

   assign sampleHold   = state == ST_SAMPLE;
   assign convertStart = state == ST_SAMPLE && timerDone;

   ads_sample_timer u_timer (
      .clk     (clk),
      .rst_b   (rst_b),
      .start   (idlePick),
      .length  (pickLen),
      .running (),
      .done    (timerDone)
   );

   // ==========================================
   // results
   ads_result_mem #(.DEPTH(CHANNEL_COUNT), .WIDTH(WORD_BITS)) u_results (
      .clk         (clk),
      .rst_b       (rst_b),
      .writeEnable (memWrite),
      .writeAddr   (convChannel),
      .writeData   (align(convertData, resultAlignmentSelect)),
      .readAddr    (readChannel),
      .readData    (channelResult)
   );

   always_ff @(posedge clk or negedge rst_b)
      if (!rst_b)
      begin
         resultValid <= 1'b0;
         result      <= '{DEST_FOC, 4'h0, RESULT_RESET};
      end
      else
      begin
         resultValid <= convEnd && curTrig;
         if (convEnd && curTrig)
            result <= '{JOB_DEST[curJob], convChannel, align(convertData, 1'b1)};
      end

   // ==========================================
   // checks
   logic       haveLast;
   logic [3:0] lastChan;
   always_ff @(posedge clk or negedge rst_b)
      if (!rst_b)
      begin
         haveLast <= 1'b0;
         lastChan <= 4'h0;
      end
      else if (startTake)
         haveLast <= 1'b0;
      else if (memWrite)
      begin
         haveLast <= 1'b1;
         lastChan <= convChannel;
      end

   sequence s_start_taken;
      startWrite && converterEnable && |channelMask && !startBusyFlag;
   endsequence
   sequence s_both_waiting;
      state == ST_IDLE && converterEnable && trigAny && seqAny;
   endsequence

   a_busy_on_start: assert property (@(posedge clk) disable iff (!rst_b)
      s_start_taken |=> startBusyFlag) else $error("start did not set busy");
   a_empty_mask: assert property (@(posedge clk) disable iff (!rst_b)
      startWrite && channelMask == 11'h000 && !startBusyFlag |=> !startBusyFlag)
      else $error("start with empty mask was taken");
   a_trig_first: assert property (@(posedge clk) disable iff (!rst_b)
      s_both_waiting |=> curTrig && state == ST_SAMPLE) else $error("sequential ran before trigger");
   a_trig_no_store: assert property (@(posedge clk) disable iff (!rst_b)
      curTrig |-> !memWrite) else $error("triggered result stored in channel word");
   a_trig_left: assert property (@(posedge clk) disable iff (!rst_b)
      resultValid |-> result.data[15] == 1'b0 && result.data[2:0] == 3'h0
      && result.data[14:3] == $past(convertData)) else $error("triggered result not left aligned");
   a_seq_ascend: assert property (@(posedge clk) disable iff (!rst_b)
      memWrite && haveLast && startBusyFlag |-> convChannel > lastChan) else $error("channel order broken");
   a_run_done: assert property (@(posedge clk) disable iff (!rst_b)
      runEnd |=> !startBusyFlag && completionFlag) else $error("run end not flagged");
   a_irq_gate: assert property (@(posedge clk) disable iff (!rst_b)
      $rose(completionFlag) |-> $past(runEnd) && completionIrq == completionIrqEnable)
      else $error("interrupt gating wrong");
   a_foc_chan: assert property (@(posedge clk) disable iff (!rst_b)
      state == ST_SAMPLE && curTrig && JOB_DEST[curJob] == DEST_FOC
      |-> convChannel inside {4'h0, 4'h1, 4'h2, 4'h4}) else $error("vector control on wrong channel");

   // ==========================================
   // checks on timer and link consumers, and on resuming a run
   // triggered work must leave completion alone, or software would read stale words
   sequence s_trig_end_clean;
      convEnd && curTrig && !completionFlag;
   endsequence

   a_timer_chan: assert property (@(posedge clk) disable iff (!rst_b)
      state == ST_SAMPLE && curTrig && JOB_DEST[curJob] == DEST_TIMER
      |-> convChannel inside {4'h4, 4'h8, 4'h9, 4'ha}) else $error("timer one on wrong channel");
   a_trig_no_flag: assert property (@(posedge clk) disable iff (!rst_b)
      s_trig_end_clean |=> !completionFlag) else $error("triggered work set completion");
   a_seq_kept: assert property (@(posedge clk) disable iff (!rst_b)
      converterEnable && !startTake && !takeSeq |=> seqPending == $past(seqPending))
      else $error("pending channel lost");
   a_seq_taken: assert property (@(posedge clk) disable iff (!rst_b)
      takeSeq |=> !seqPending[$past(pickSeq)]) else $error("taken channel still pending");
   a_lin_dest: assert property (@(posedge clk) disable iff (!rst_b)
      resultValid && result.dest == DEST_LIN |-> result.channel == LIN_CHANNEL) else $error("link result on wrong channel");
endmodule : ads_sequencer

// ---- testbench/ads_conv_model.sv ----
`timescale 1ns/1ns
module ads_conv_model
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_b,
   // converter request
   input  wire logic        convertStart,
   input  wire logic [3:0]  convChannel,
   // bench controls
   input  wire logic        slow,
   input  wire logic [11:0] baseLevel,
   // converter answer
   output logic             convertDone,
   output logic [11:0]      convertData
);
   // ==========================================
   // one conversion in flight; level depends on the channel so swaps show up
   logic [5:0]  waitCount;
   logic [11:0] heldData;

   always_ff @(posedge clk or negedge rst_b)
      if (!rst_b)
      begin
         waitCount   <= 6'h00;
         heldData    <= 12'h000;
         convertDone <= 1'b0;
         convertData <= 12'h000;
      end
      else
      begin
         convertDone <= 1'b0;
         // stale data flips every cycle so nobody may rely on it
         convertData <= ~convertData;
         if (convertStart)
         begin
            waitCount <= slow ? 6'h14 : 6'h02;
            heldData  <= baseLevel + {4'h0, convChannel, convChannel};
         end
         else if (waitCount != 6'h00)
         begin
            waitCount <= waitCount - 6'h01;
            if (waitCount == 6'h01)
            begin
               convertDone <= 1'b1;
               convertData <= heldData;
            end
         end
      end
endmodule : ads_conv_model

// ---- testbench/tb.sv ----
`timescale 1ns/1ns
module tb;
   import ads_pkg::*;
   // ==========================================
   // signals
   logic           clk = 1'b0;
   logic           rst_b = 1'b0;
   logic           converterEnable = 1'b0;
   logic           startWrite = 1'b0;
   logic [10:0]    channelMask = 11'h000;
   logic           resultAlignmentSelect = 1'b0;
   logic           completionIrqEnable = 1'b0;
   logic           completionClear = 1'b0;
   logic [7:0]     sampleLengthLowGroups = 8'h33;
   logic [1:0]     sampleLengthHighGroup = 2'h1;
   logic [3:0]     readChannel = 4'h0;
   ads_trig_type   trigger = '0;
   ads_mode_type   modeConfig = '0;
   logic           slow = 1'b0;
   logic [11:0]    baseLevel = 12'h000;
   logic           startBusyFlag, completionFlag, completionIrq, resultValid;
   logic           sampleHold, convertStart, convertDone;
   logic [15:0]    channelResult;
   ads_result_type result;
   logic [3:0]     convChannel;
   logic [11:0]    convertData;
   logic [15:0]    expWord [12];
   int             holdLen [16];
   int             holdCount = 0;
   int             num_errors = 0;
   int             checked = 0;
   logic [3:0]     cq [$];
   ads_result_type rq [$];

   always #5 clk = ~clk;

   ads_sequencer ads_sequencer_i (.clk, .rst_b, .converterEnable, .startWrite, .channelMask,
      .resultAlignmentSelect, .completionIrqEnable, .completionClear, .sampleLengthLowGroups,
      .sampleLengthHighGroup, .startBusyFlag, .completionFlag, .completionIrq, .readChannel,
      .channelResult, .trigger, .modeConfig, .resultValid, .result, .sampleHold, .convChannel,
      .convertStart, .convertDone, .convertData);
   ads_conv_model ads_conv_model_i (.clk, .rst_b, .convertStart, .convChannel, .slow, .baseLevel,
      .convertDone, .convertData);

   // ==========================================
   // monitor: sample lengths, conversion order, triggered results
   always @(posedge clk)
   begin
      holdCount = (sampleHold === 1'b1) ? holdCount + 1 : 0;
      if (convertStart === 1'b1)
      begin
         holdLen[convChannel] = holdCount;
         cq.push_back(convChannel);
      end
      if (resultValid === 1'b1)
         rq.push_back(result);
   end

   // ==========================================
   // tasks
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp)
      begin
         num_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   function automatic int exp_hold(input int ch);
      if (ch <= 4)
         return sampleLengthLowGroups[3:0] * 10;
      if (ch <= 7)
         return (sampleLengthLowGroups[7] ? sampleLengthLowGroups[6:4] * 8 + 7 : sampleLengthLowGroups[6:4]) * 10;
      return (sampleLengthHighGroup * 16 + (sampleLengthHighGroup[1] ? 0 : 12)) * 10;
   endfunction : exp_hold

   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : end_of_test

   task automatic read_all;
      for (int c = 0; c < 12; c++)
      begin
         @(negedge clk);
         readChannel = 4'(c);
         @(negedge clk);
         check("result", expWord[c], channelResult);
      end
   endtask : read_all

   task automatic start_seq(input logic [10:0] mask, input logic left, input logic [11:0] lvl, input ads_trig_type t);
      @(negedge clk);
      channelMask = mask;
      resultAlignmentSelect = left;
      baseLevel = lvl;
      cq.delete();
      startWrite = 1'b1;
      trigger = t;
      @(negedge clk);
      startWrite = 1'b0;
      trigger = '0;
   endtask : start_seq

   // waits for the run, then checks flags, sample lengths, order and words
   task automatic wait_seq(input logic [10:0] mask, input logic left, input logic [11:0] lvl);
      int n;
      logic [11:0] d;
      logic [3:0] got;
      check("busy", 16'h1, startBusyFlag);
      n = 0;
      while (startBusyFlag === 1'b1 && n < 9000)
      begin
         @(negedge clk);
         n++;
      end
      check("busy end", 16'h0, startBusyFlag);
      @(negedge clk);
      check("flag", 16'h1, completionFlag);
      check("irq", completionIrqEnable, completionIrq);
      for (int c = 0; c < 11; c++)
         if (mask[c])
         begin
            d = lvl + {4'h0, 4'(c), 4'(c)};
            expWord[c] = left ? {1'b0, d, 3'h0} : {4'h0, d};
            check("hold", 16'(exp_hold(c)), 16'(holdLen[c]));
            while (cq.size() > 0 && !mask[cq[0]])
               void'(cq.pop_front());
            got = (cq.size() > 0) ? cq.pop_front() : 4'hf;
            check("order", 16'(c), 16'(got));
         end
      while (cq.size() > 0 && !mask[cq[0]])
         void'(cq.pop_front());
      check("repeats", 16'h0, 16'(cq.size()));
      read_all();
   endtask : wait_seq

   // mode bits: focEnable, shuntMode[1:0], busVoltageChannelSelect, timerOneEnable, positionSourceSelect
   task automatic trig_case(input ads_trig_type t, input ads_mode_type m, input logic [11:0] chans,
                            input int cnt, input ads_dest_type dst);
      int n;
      logic [11:0] d;
      @(negedge clk);
      modeConfig = m;
      rq.delete();
      @(negedge clk);
      trigger = t;
      @(negedge clk);
      trigger = '0;
      n = 0;
      while (rq.size() < cnt && n < 2000)
      begin
         @(negedge clk);
         n++;
      end
      repeat (400) @(negedge clk);
      check("count", 16'(cnt), 16'(rq.size()));
      for (int i = 0; i < cnt && i < rq.size(); i++)
      begin
         d = baseLevel + {4'h0, chans[4*i +: 4], chans[4*i +: 4]};
         check("channel", 16'(chans[4*i +: 4]), 16'(rq[i].channel));
         check("dest", 16'(dst), 16'(rq[i].dest));
         check("data", {1'b0, d, 3'h0}, rq[i].data);
      end
      read_all();
   endtask : trig_case

   // ==========================================
   // tests
   initial
   begin
      for (int c = 0; c < 12; c++)
         expWord[c] = 16'h0000;
      repeat (3) @(negedge clk);
      rst_b = 1'b1;
      read_all();
      start_seq(11'h004, 1'b0, 12'h111, '0);
      check("busy off", 16'h0, startBusyFlag);
      converterEnable = 1'b1;
      start_seq(11'h000, 1'b0, 12'h111, '0);
      check("busy empty", 16'h0, startBusyFlag);
      $display("test refusals done");
      completionIrqEnable = 1'b1;
      start_seq(11'h124, 1'b0, 12'h123, '0);
      wait_seq(11'h124, 1'b0, 12'h123);
      completionClear = 1'b1;
      @(negedge clk);
      completionClear = 1'b0;
      check("flag clr", 16'h0, completionFlag);
      check("irq clr", 16'h0, completionIrq);
      sampleLengthLowGroups = 8'hb4;
      sampleLengthHighGroup = 2'h2;
      completionIrqEnable = 1'b0;
      slow = 1'b1;
      start_seq(11'h7ff, 1'b1, 12'h456, '0);
      wait_seq(11'h7ff, 1'b1, 12'h456);
      $display("test sequences done");
      sampleLengthLowGroups = 8'h33;
      sampleLengthHighGroup = 2'h1;
      slow = 1'b0;
      for (int i = 0; i < 3; i++)
      begin
         start_seq(11'h001, i != 1, i == 0 ? 12'hfff : 12'h800, '0);
         wait_seq(11'h001, i != 1, i == 0 ? 12'hfff : 12'h800);
      end
      $display("test scale done");
      modeConfig = 6'h03;
      start_seq(11'h013, 1'b0, 12'h321, 5'h01);
      repeat (60) @(negedge clk);
      check("first", 16'h3, 16'(cq[0]));
      trigger = 5'h02;
      @(negedge clk);
      trigger = '0;
      wait_seq(11'h013, 1'b0, 12'h321);
      $display("test priority done");
      trig_case(5'h10, 6'h20, 12'h004, 1, DEST_FOC);
      trig_case(5'h10, 6'h28, 12'h010, 2, DEST_FOC);
      trig_case(5'h10, 6'h30, 12'h410, 3, DEST_FOC);
      trig_case(5'h08, 6'h24, 12'h002, 1, DEST_FOC);
      trig_case(5'h08, 6'h20, 12'h000, 0, DEST_FOC);
      trig_case(5'h04, 6'h02, 12'h004, 1, DEST_TIMER);
      trig_case(5'h02, 6'h03, 12'h89a, 3, DEST_TIMER);
      trig_case(5'h01, 6'h00, 12'h003, 1, DEST_LIN);
      $display("test triggers done");
      end_of_test();
   end

   // about four times the expected run length, well inside the cycle budget
   initial
   begin
      #300_000;
      num_errors++;
      $display("BAD watchdog expected finish seen hang");
      end_of_test();
   end
endmodule : tb
